// file: hw/snti_cfg.svh
// constants for the synchronous no-turnaround sram interface
`ifndef SNTI_CFG_SVH
`define SNTI_CFG_SVH

// data path shape
`define SNTI_LANES      4
`define SNTI_LANE_W     9
`define SNTI_BYTE_W     8
// address width of the modelled array and its depth
`define SNTI_ADDR_W     10
`define SNTI_DEPTH      1024
// burst counter width and the field of the address it presets from
`define SNTI_BEAT_W     2
`define SNTI_BEAT_LSB   0
`define SNTI_BEAT_MSB   1
// reset values
`define SNTI_BEAT_RST   2'h0
`define SNTI_LANES_RST  4'h0
// read latency in edges from command to data on the pins
`define SNTI_FLOW_LAT   1
`define SNTI_PIPE_LAT   2

`endif

// file: hw/snti_pkg.sv
// types shared by the sram interface design files
`include "snti_cfg.svh"

package snti_pkg;

	// one nine-bit byte lane: data byte plus its ninth bit
	typedef struct packed {
		logic                      ninth;
		logic [`SNTI_BYTE_W-1:0]   data;
	} snti_lane_t;

	// full data word, lane 0 in the low bits
	typedef snti_lane_t [`SNTI_LANES-1:0] snti_word_t;

	// pending write waiting for its late data
	typedef struct packed {
		logic                      valid;
		logic [`SNTI_ADDR_W-1:0]   addr;
		logic [`SNTI_LANES-1:0]    lanes;
	} snti_wop_t;

	// kind of the operation in progress
	typedef enum logic [2:0] {
		SNTI_DESEL = 3'b001,
		SNTI_READ  = 3'b010,
		SNTI_WRITE = 3'b100
	} snti_kind_t;

endpackage

// file: hw/snti_mem.sv
// lane-writable array with registered, write-first read data
`timescale 1ns/1ps
`default_nettype none
`include "snti_cfg.svh"

module snti_mem (
	// clock
	input  wire logic                        ref_clk,
	// read side
	input  wire logic                        rd_en,
	input  wire logic [`SNTI_ADDR_W-1:0]     rd_addr,
	output var  snti_pkg::snti_word_t        rd_data,
	// write side
	input  wire logic                        wr_en,
	input  wire logic [`SNTI_ADDR_W-1:0]     wr_addr,
	input  wire logic [`SNTI_LANES-1:0]      wr_lane_en,
	input  wire snti_pkg::snti_word_t        wr_data
);

	// one storage column per lane
	genvar g;
	generate
		for (g = 0; g < `SNTI_LANES; g = g + 1) begin : g_lane
			logic [`SNTI_LANE_W-1:0] cells [0:`SNTI_DEPTH-1];
			logic                    hit;

			// same-edge write to the read address is forwarded
			assign hit = wr_en && wr_lane_en[g] && (wr_addr == rd_addr);

			// write only the enabled lane
			always_ff @(posedge ref_clk) begin
				if (wr_en && wr_lane_en[g]) begin
					cells[wr_addr] <= wr_data[g];
				end
			end

			// registered read, new data wins on collision
			always_ff @(posedge ref_clk) begin
				if (rd_en) begin
					rd_data[g] <= hit ? wr_data[g] : cells[rd_addr];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// file: hw/snti_sram.sv
// synchronous sram core with late write and no bus turnaround
`timescale 1ns/1ps
`default_nettype none
`include "snti_cfg.svh"

module snti_sram (
	// clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        sys_rst,
	input  wire logic                        clk_en_n,
	// command pins
	input  wire logic [`SNTI_ADDR_W-1:0]     addr,
	input  wire logic                        write_n,
	input  wire logic                        select_low_a,
	input  wire logic                        select_high,
	input  wire logic                        select_low_b,
	input  wire logic                        burst_step,
	input  wire logic [`SNTI_LANES-1:0]      lane_write_n,
	// data pins split into in, out and enable
	input  wire snti_pkg::snti_word_t        data_in,
	output var  snti_pkg::snti_word_t        data_out,
	output logic                             data_oe,
	// asynchronous and static controls
	input  wire logic                        output_en_n,
	input  wire logic                        sleep_req,
	input  wire logic                        burst_order_sel,
	input  wire logic                        latency_mode_sel
);

	logic                              ce;
	logic                              selected;
	snti_pkg::snti_kind_t              kind_reg;
	snti_pkg::snti_kind_t              cur_kind;
	logic [`SNTI_ADDR_W-1:0]           cur_addr;
	logic [`SNTI_ADDR_W-1:0]           base_reg;
	logic [`SNTI_BEAT_W-1:0]           start_reg;
	logic [`SNTI_BEAT_W-1:0]           beat_reg;
	logic [`SNTI_BEAT_W-1:0]           beat_next;
	logic [`SNTI_BEAT_W-1:0]           burst_lo;
	snti_pkg::snti_wop_t               wop_s1_reg;
	snti_pkg::snti_wop_t               wop_s2_reg;
	snti_pkg::snti_wop_t               wop_commit;
	logic                              rd1_reg;
	logic                              rd2_reg;
	snti_pkg::snti_word_t              out_reg;
	snti_pkg::snti_word_t              mem_rdata;
	logic                              mem_rd_en;
	logic                              mem_we;
	logic                              drive_now;

	// low clock enable pin lets edges through
	assign ce = !clk_en_n;

	// all three enables at their active levels
	assign selected = !select_low_a && select_high && !select_low_b;

	// next beat and its low address bits within the aligned group
	assign beat_next = beat_reg + `SNTI_BEAT_W'(1);
	always_comb begin
		if (!burst_order_sel) begin
			burst_lo = start_reg + beat_next;
		end else begin
			burst_lo = start_reg ^ beat_next;
		end
	end

	// decode the operation presented at this edge
	always_comb begin
		cur_kind = snti_pkg::SNTI_DESEL;
		cur_addr = addr;
		if (sleep_req) begin
			cur_kind = snti_pkg::SNTI_DESEL;
		end else if (burst_step) begin
			cur_kind = kind_reg;
			cur_addr = base_reg;
			cur_addr[`SNTI_BEAT_MSB:`SNTI_BEAT_LSB] = burst_lo;
		end else if (selected) begin
			cur_kind = write_n ? snti_pkg::SNTI_READ : snti_pkg::SNTI_WRITE;
		end
	end

	// burst state: load on a new command, count on a step
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			kind_reg  <= snti_pkg::SNTI_DESEL;
			base_reg  <= '0;
			start_reg <= `SNTI_BEAT_RST;
			beat_reg  <= `SNTI_BEAT_RST;
		end else if (ce) begin
			if (burst_step && !sleep_req) begin
				beat_reg <= beat_next;
			end else begin
				kind_reg  <= cur_kind;
				base_reg  <= addr;
				start_reg <= addr[`SNTI_BEAT_MSB:`SNTI_BEAT_LSB];
				beat_reg  <= `SNTI_BEAT_RST;
			end
		end
	end

	// write pipeline holding address and lane strobes until data arrives
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wop_s1_reg <= '0;
			wop_s2_reg <= '0;
		end else if (ce) begin
			wop_s1_reg.valid <= (cur_kind == snti_pkg::SNTI_WRITE);
			wop_s1_reg.addr  <= cur_addr;
			wop_s1_reg.lanes <= ~lane_write_n;
			wop_s2_reg       <= wop_s1_reg;
		end
	end

	// flow-through takes data one edge late, pipelined two
	assign wop_commit = latency_mode_sel ? wop_s2_reg : wop_s1_reg;
	// sleep blocks the array write even for a command taken before it
	assign mem_we     = ce && wop_commit.valid && !sleep_req;
	assign mem_rd_en  = ce && (cur_kind == snti_pkg::SNTI_READ);

	// array with self-timed lane writes
	snti_mem u_mem (
		.ref_clk    (ref_clk),
		.rd_en      (mem_rd_en),
		.rd_addr    (cur_addr),
		.rd_data    (mem_rdata),
		.wr_en      (mem_we),
		.wr_addr    (wop_commit.addr),
		.wr_lane_en (wop_commit.lanes),
		.wr_data    (data_in)
	);

	// read valid trackers for both latencies
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rd1_reg <= 1'b0;
			rd2_reg <= 1'b0;
		end else if (ce) begin
			rd1_reg <= (cur_kind == snti_pkg::SNTI_READ);
			rd2_reg <= rd1_reg;
		end
	end

	// output register releases array data one edge later
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			out_reg <= '0;
		end else if (ce && rd1_reg) begin
			out_reg <= mem_rdata;
		end
	end

	// pin drive: mode picks source, enable and sleep gate without clock
	assign drive_now = latency_mode_sel ? rd2_reg : rd1_reg;
	assign data_out  = latency_mode_sel ? out_reg : mem_rdata;
	assign data_oe   = drive_now && !output_en_n && !sleep_req;

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	// helper: clock enable one edge back
	logic past_ce;
	always_ff @(posedge ref_clk) begin
		past_ce <= ce;
	end

	output_gate_a: assert property (output_en_n |-> !data_oe)
		else $error("data driven while output enable off");

	sleep_gate_a: assert property (sleep_req |-> !data_oe && !mem_we)
		else $error("activity during sleep");

	select_decode_a: assert property (
		ce && !burst_step && !sleep_req && (select_low_a || !select_high || select_low_b)
		|=> !rd1_reg && !wop_s1_reg.valid)
		else $error("deselected device started an operation");

	flow_read_a: assert property (
		ce && !latency_mode_sel && !sleep_req && !burst_step && selected && write_n
		|=> drive_now && !output_en_n && !sleep_req |-> data_oe)
		else $error("flow-through read not on pins after one edge");

	pipe_read_a: assert property (
		ce && latency_mode_sel && cur_kind == snti_pkg::SNTI_READ ##1 ce
		|=> rd2_reg && data_out == $past(mem_rdata))
		else $error("pipelined read data not from output register");

	late_write_a: assert property (
		ce && latency_mode_sel && cur_kind == snti_pkg::SNTI_WRITE ##1 ce
		|=> ce && !sleep_req |-> mem_we && wop_commit.addr == $past(cur_addr, 2))
		else $error("pipelined write data not taken two edges late");

	flow_write_a: assert property (
		ce && !latency_mode_sel && cur_kind == snti_pkg::SNTI_WRITE
		|=> ce && !sleep_req |-> mem_we && wop_commit.lanes == $past(~lane_write_n))
		else $error("flow-through write lost or wrong lanes");

	lane_mask_a: assert property (ce && cur_kind == snti_pkg::SNTI_WRITE
		|=> wop_s1_reg.valid && wop_s1_reg.lanes == ~$past(lane_write_n))
		else $error("write lane strobes not captured with command");

	back_to_back_a: assert property (
		ce && rd1_reg && !sleep_req && !burst_step && selected && !write_n
		|=> wop_s1_reg.valid)
		else $error("write after read needed a dead cycle");

	burst_count_a: assert property (
		ce && burst_step && !sleep_req |=> beat_reg == $past(beat_reg) + `SNTI_BEAT_W'(1))
		else $error("burst counter did not advance");

	burst_addr_a: assert property (
		burst_step && !sleep_req && !burst_order_sel
		|-> cur_addr[`SNTI_BEAT_MSB:`SNTI_BEAT_LSB] == start_reg + beat_next)
		else $error("linear burst address wrong");

	freeze_a: assert property (!ce |=> $stable(rd1_reg) && $stable(beat_reg)
		&& $stable(wop_s1_reg) && $stable(out_reg))
		else $error("state moved while clock gated");

	capture_a: assert property (past_ce && !ce |-> !mem_we && !mem_rd_en)
		else $error("array touched on a gated edge");

	// pin drive only inside a read slot
	no_slot_drive_a: assert property (!rd1_reg && !rd2_reg |-> !data_oe)
		else $error("data driven outside a read slot");

	// pipelined read must not reach the pins one edge early
	pipe_early_a: assert property (
		ce && latency_mode_sel && cur_kind == snti_pkg::SNTI_READ && !rd1_reg
		|=> !drive_now)
		else $error("pipelined read on pins too early");

	// four-beat counter wraps back to its first beat
	burst_wrap_a: assert property (
		ce && burst_step && !sleep_req && beat_reg == 2'h3 |=> beat_reg == 2'h0)
		else $error("burst counter did not wrap");

	// a stepped beat repeats the kind of the loaded command
	burst_kind_a: assert property (burst_step && !sleep_req |-> cur_kind == kind_reg)
		else $error("burst beat changed operation kind");

	// a stepped beat keeps the upper address bits of the loaded command
	burst_base_a: assert property (burst_step && !sleep_req
		|-> cur_addr[`SNTI_ADDR_W-1:`SNTI_BEAT_MSB+1] == base_reg[`SNTI_ADDR_W-1:`SNTI_BEAT_MSB+1])
		else $error("burst beat left its aligned group");

	// interleaved order flips the low bits by the beat number
	burst_xor_a: assert property (
		burst_step && !sleep_req && burst_order_sel
		|-> cur_addr[`SNTI_BEAT_MSB:`SNTI_BEAT_LSB] == (start_reg ^ beat_next))
		else $error("interleaved burst address wrong");

	// sleep refuses any new command
	sleep_refuse_a: assert property (ce && sleep_req |=> !rd1_reg && !wop_s1_reg.valid)
		else $error("command taken during sleep");

	// a write command never starts an array read
	write_no_read_a: assert property (cur_kind == snti_pkg::SNTI_WRITE |-> !mem_rd_en)
		else $error("write command started a read");

	// a read after a write needs no dead cycle either
	read_after_write_a: assert property (
		ce && wop_s1_reg.valid && !sleep_req && !burst_step && selected && write_n
		|=> rd1_reg)
		else $error("read after write needed a dead cycle");

	// flow-through pins carry the array read register directly
	flow_source_a: assert property (!latency_mode_sel |-> data_out == mem_rdata)
		else $error("flow-through data not from array register");

	// scenarios worth seeing
	cov_pipe_read: cover property (latency_mode_sel && rd2_reg && data_oe);
	cov_flow_write: cover property (!latency_mode_sel && mem_we);
	cov_read_write_read: cover property (
		rd1_reg && wop_s1_reg.valid == 1'b0 ##1 wop_s1_reg.valid ##1 rd1_reg);
	cov_full_burst: cover property (ce && burst_step && beat_reg == 2'h2);

endmodule

`default_nettype wire

// file: verif/snti_ctrl_model.sv
// controller stand-in that drives late write data onto the sram data pins
`timescale 1ns/1ps
`default_nettype none

module snti_ctrl_model (
	// clock and static mode
	input  wire logic                 ref_clk,
	input  wire logic                 clk_en_n,
	input  wire logic                 pipe,
	// write request issued with the command
	input  wire logic                 wr_cmd,
	input  wire snti_pkg::snti_word_t wr_word,
	// data pins toward the sram
	output var snti_pkg::snti_word_t  data_in
);
	logic [1:0]           wv = 2'h0;
	snti_pkg::snti_word_t wd [2] = '{36'h0, 36'h0};

	// delay the write word by enabled edges only
	always @(posedge ref_clk) begin
		if (!clk_en_n) begin
			wv <= {wv[0], wr_cmd};
			wd[0] <= wr_word;
			wd[1] <= wd[0];
		end
	end

	// owed data one or two edges late, else its inverse
	always_comb begin
		if (wv[pipe])
			data_in = wd[pipe];
		else
			data_in = ~wd[pipe];
	end
endmodule

`default_nettype wire

// file: verif/sync_sram_noturn_interface_bench.sv
// self-checking bench for the sram core in both latency modes
`timescale 1ns/1ps
`default_nettype none

module sync_sram_noturn_interface_bench;
	typedef struct packed {
		logic                 w;
		logic [9:0]           a;
		logic [3:0]           l;
		snti_pkg::snti_word_t d;
	} snti_row_t;
	localparam snti_row_t ROWS [10] = '{
		{1'b1, 10'h005, 4'h0, 36'h1_2345_6789}, {1'b1, 10'h3ff, 4'h0, 36'hf_edcb_a987},
		{1'b1, 10'h000, 4'h0, 36'h8_0402_0100}, {1'b0, 10'h005, 4'h0, 36'h0},
		{1'b1, 10'h005, 4'ha, 36'h0_ffff_ffff}, {1'b0, 10'h3ff, 4'h0, 36'h0},
		{1'b1, 10'h3ff, 4'h7, 36'h5_5555_5555}, {1'b0, 10'h000, 4'h0, 36'h0},
		{1'b0, 10'h3ff, 4'h0, 36'h0}, {1'b0, 10'h005, 4'h0, 36'h0}};
	localparam logic [2:0] SELS [3] = '{3'b110, 3'b000, 3'b011};

	logic                 ref_clk, sys_rst, clk_en_n, write_n, burst_step, output_en_n, sleep_req, mode;
	logic                 data_oe, wr_cmd, rd_issue, slp;
	logic [9:0]           addr;
	logic [3:0]           lane_write_n;
	logic [2:0]           csel;
	logic [1:0]           pv;
	snti_pkg::snti_word_t data_in, data_out, wr_word, rd_exp;
	snti_pkg::snti_word_t pd [2];
	snti_pkg::snti_word_t shadow [1024];
	int                   n_mismatch, checks;

	snti_sram dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en_n(clk_en_n), .addr(addr), .write_n(write_n),
		.select_low_a(csel[2]), .select_high(csel[1]), .select_low_b(csel[0]), .burst_step(burst_step),
		.lane_write_n(lane_write_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.output_en_n(output_en_n), .sleep_req(sleep_req), .burst_order_sel(mode), .latency_mode_sel(mode));
	snti_ctrl_model ctrl_u (.ref_clk(ref_clk), .clk_en_n(clk_en_n), .pipe(mode), .wr_cmd(wr_cmd),
		.wr_word(wr_word), .data_in(data_in));

	// 25 mhz clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic ok, input string m);
		checks++;
		if (!ok) begin
			n_mismatch++;
			$display("ERROR at %0t: %s", $time, m);
		end
	endtask

	task automatic summarize();
		$display("checks %0d, mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// expected read slots, frozen while the clock is gated
	always @(posedge ref_clk) begin
		if (sys_rst) begin
			pv <= 2'h0;
		end else if (!clk_en_n) begin
			pv <= {pv[0], rd_issue};
			pd[0] <= rd_exp;
			pd[1] <= pd[0];
		end
	end

	// compare the pins mid-cycle where they have settled
	always @(negedge ref_clk) begin
		if (!sys_rst) begin
			chk(data_oe === (pv[mode] && !output_en_n && !sleep_req), "drive enable");
			if (data_oe === 1'b1)
				chk(data_out === pd[mode], "read data");
		end
	end

	// one bus cycle; the shadow array tracks what should be stored
	task automatic cmd(input logic w, input logic s, input logic [9:0] pa, input logic [9:0] ea,
		input logic [3:0] l, input snti_pkg::snti_word_t d, input logic [2:0] cs);
		logic ok;
		@(posedge ref_clk);
		ok = cs == 3'b010 && !slp;
		addr <= pa;
		write_n <= !w;
		burst_step <= s;
		lane_write_n <= l;
		csel <= cs;
		sleep_req <= slp;
		wr_word <= d;
		wr_cmd <= ok && w;
		rd_issue <= ok && !w;
		rd_exp <= shadow[ea];
		for (int i = 0; i < 4; i++)
			if (ok && w && !l[i])
				shadow[ea][i] = d[i];
	endtask

	// four-beat burst; pins carry a wrong address on stepped beats
	task automatic burst(input logic w, input logic [9:0] a);
		logic [1:0] b;
		for (int i = 0; i < 4; i++) begin
			b = mode ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i);
			cmd(w, i != 0, i != 0 ? ~a : a, {a[9:2], b}, 4'h0, {4'(i), 32'h2468_ace0 + 32'(i)}, 3'b010);
		end
	endtask

	task automatic run_mode(input logic m);
		mode <= m;
		sys_rst <= 1'b1;
		repeat (6) @(posedge ref_clk);
		sys_rst <= 1'b0;
		@(negedge ref_clk);
		chk(data_oe === 1'b0 && (!m || data_out === 36'h0), "reset state");
		foreach (ROWS[j])
			cmd(ROWS[j].w, 1'b0, ROWS[j].a, ROWS[j].a, ROWS[j].l, ROWS[j].d, 3'b010);
		$display("rows done, mode %0d", m);
		burst(1'b1, 10'h102);
		burst(1'b0, 10'h103);
		$display("bursts done");
		foreach (SELS[j]) begin
			cmd(1'b1, 1'b0, 10'h005, 10'h005, 4'h0, 36'h0, SELS[j]);
			cmd(1'b0, 1'b0, 10'h005, 10'h005, 4'h0, 36'h0, SELS[j]);
		end
		cmd(1'b0, 1'b0, 10'h005, 10'h005, 4'hf, 36'h0, 3'b010);
		$display("deselect done");
		slp = 1'b1;
		cmd(1'b1, 1'b0, 10'h005, 10'h005, 4'h0, 36'h0, 3'b010);
		cmd(1'b0, 1'b0, 10'h3ff, 10'h3ff, 4'hf, 36'h0, 3'b010);
		cmd(1'b0, 1'b0, 10'h000, 10'h000, 4'hf, 36'h0, 3'b000);
		slp = 1'b0;
		cmd(1'b0, 1'b0, 10'h005, 10'h005, 4'hf, 36'h0, 3'b010);
		output_en_n <= 1'b1;
		cmd(1'b0, 1'b0, 10'h3ff, 10'h3ff, 4'hf, 36'h0, 3'b010);
		cmd(1'b0, 1'b0, 10'h000, 10'h000, 4'hf, 36'h0, 3'b000);
		cmd(1'b0, 1'b0, 10'h000, 10'h000, 4'hf, 36'h0, 3'b000);
		output_en_n <= 1'b0;
		$display("sleep and output enable done");
		cmd(1'b0, 1'b0, 10'h3ff, 10'h3ff, 4'hf, 36'h0, 3'b010);
		@(posedge ref_clk);
		clk_en_n <= 1'b1;
		csel <= 3'b000;
		rd_issue <= 1'b0;
		repeat (3) @(posedge ref_clk);
		clk_en_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		$display("clock gate done");
	endtask

	// main sequence: flow-through first, then pipelined after a second reset
	initial begin
		{sys_rst, clk_en_n, write_n, burst_step, output_en_n, sleep_req, mode} = 7'b1010000;
		addr = 10'h000;
		lane_write_n = 4'hf;
		csel = 3'b000;
		wr_cmd = 1'b0;
		slp = 1'b0;
		rd_issue = 1'b0;
		wr_word = 36'h0;
		rd_exp = 36'h0;
		n_mismatch = 0;
		checks = 0;
		run_mode(1'b0);
		run_mode(1'b1);
		summarize();
	end

	// watchdog against a hung run
	initial begin
		repeat (5000) @(posedge ref_clk);
		n_mismatch++;
		summarize();
	end
endmodule

`default_nettype wire
